// *** hdl/tlp_line_port.sv ***
// line-side port of one ds1 framer channel: rail/nrz receive and transmit,
// violation counting, fast sync, wishbone registers and one interrupt.
// assumes rx_line_clock and rail inputs are asynchronous to clk; user side
// supplies transmit symbols after each tx_bit_req and takes rx symbols.
//
// Summary of operation
// - rail mode: positive receive rail high marks a received positive pulse
// - rail mode: negative receive rail high marks a received negative pulse
// - nrz mode: one receive data input, high for any received pulse
// - receive nrz invert set: data input is active low, inverted before use
// - nrz, no rx fast sync: violation input counted each rising clock
// - nrz with rx fast sync: input pulse marks bit 192 of last frame
// - receive data and fast sync taken on rising or falling line clock per edge bit; violations always on rising
// - rail mode: positive transmit rail high for each positive pulse
// - rail mode: negative transmit rail high for each negative pulse
// - nrz mode: one transmit data output, high for any pulse sent
// - transmit nrz invert set: transmit data output is active low
// - nrz, no tx fast sync: general output bit sent on rising edges
// - nrz with tx fast sync: one-bit-period pulse at bit 192 of chosen frame
// - framing field 11 selects esf, 01 selects sf
// - 1544 kHz transmit clock out; launch on rising or falling edge
`timescale 1ns/1ps
module tlp_line_port #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic rx_line_clock,
	input wire logic rx_pos_rail,
	input wire logic rx_neg_rail,
	output logic tx_line_clock,
	output logic tx_pos_rail,
	output logic tx_neg_rail,
	output logic rx_pos_out,
	output logic rx_neg_out,
	output logic rx_valid,
	output logic rx_frame_sync,
	input wire logic tx_pos_in,
	input wire logic tx_neg_in,
	output logic tx_bit_req
);

	if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
		$error("CNT_W must lie in 1..32");
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone slave and control registers
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic [7:0] ctrl_r, ctrl_nxt, pol_r, pol_nxt, frm_r, frm_nxt;
	logic [7:0] fsr_r, fsr_nxt, mask_r, mask_nxt;
	logic req, wr, rd_cnt, rd_stat;
	logic [5:0] idx;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [3:0] stat_r, stat_nxt;
	logic irq_r, irq_nxt;

	// mode decode from the control registers
	logic rail, nrz, rx_inv, tx_inv, rx_edge, tx_edge, rx_fs_en, tx_fs_en, esf, sf;
	logic [1:0] fmd;
	assign rail = ctrl_r[tlp_pkg::BIT_RAIL];
	assign nrz = !rail;
	assign rx_inv = pol_r[tlp_pkg::BIT_RX_INV];
	assign tx_inv = pol_r[tlp_pkg::BIT_TX_INV];
	assign rx_edge = pol_r[tlp_pkg::BIT_RX_EDGE];
	assign tx_edge = pol_r[tlp_pkg::BIT_TX_EDGE];
	assign rx_fs_en = fsr_r[tlp_pkg::BIT_RX_FS];
	assign tx_fs_en = fsr_r[tlp_pkg::BIT_TX_FS];
	assign fmd = {frm_r[tlp_pkg::BIT_FMD_HI], frm_r[tlp_pkg::BIT_FMD_LO]};
	assign esf = (fmd == tlp_pkg::FMD_ESF);
	assign sf = (fmd == tlp_pkg::FMD_SF);

	// one request per ack; the idle cycle after ack keeps reads from repeating
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign idx = wb_adr_i[7:2];
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd_cnt = req && !wb_we_i && (idx == tlp_pkg::IDX_VIOL_CNT);
	assign rd_stat = req && !wb_we_i && (idx == tlp_pkg::IDX_IRQ_STAT);

	// register write and read-data next values
	always_comb begin
		ack_nxt = req;
		dat_nxt = 32'h0000_0000;
		ctrl_nxt = ctrl_r;
		pol_nxt = pol_r;
		frm_nxt = frm_r;
		fsr_nxt = fsr_r;
		mask_nxt = mask_r;
		if (wr) begin
			if (idx == tlp_pkg::IDX_LINE_CTRL) begin
				ctrl_nxt = wb_dat_i[7:0] & tlp_pkg::WM_LINE_CTRL;
			end else if (idx == tlp_pkg::IDX_EDGE_POL) begin
				pol_nxt = wb_dat_i[7:0] & tlp_pkg::WM_EDGE_POL;
			end else if (idx == tlp_pkg::IDX_FRAMING) begin
				frm_nxt = wb_dat_i[7:0] & tlp_pkg::WM_FRAMING;
			end else if (idx == tlp_pkg::IDX_FAST_SYNC) begin
				fsr_nxt = wb_dat_i[7:0] & tlp_pkg::WM_FAST_SYNC;
			end else if (idx == tlp_pkg::IDX_IRQ_MASK) begin
				mask_nxt = wb_dat_i[7:0] & tlp_pkg::WM_IRQ;
			end
		end
		// unmapped reads answer zero
		if (req && !wb_we_i) begin
			if (idx == tlp_pkg::IDX_LINE_CTRL) begin
				dat_nxt = {24'h00_0000, ctrl_r};
			end else if (idx == tlp_pkg::IDX_EDGE_POL) begin
				dat_nxt = {24'h00_0000, pol_r};
			end else if (idx == tlp_pkg::IDX_FRAMING) begin
				dat_nxt = {24'h00_0000, frm_r};
			end else if (idx == tlp_pkg::IDX_FAST_SYNC) begin
				dat_nxt = {24'h00_0000, fsr_r};
			end else if (idx == tlp_pkg::IDX_VIOL_CNT) begin
				dat_nxt = 32'(cnt_r);
			end else if (idx == tlp_pkg::IDX_IRQ_STAT) begin
				dat_nxt = {28'h000_0000, stat_r};
			end else if (idx == tlp_pkg::IDX_IRQ_MASK) begin
				dat_nxt = {24'h00_0000, mask_r};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
			ctrl_r <= tlp_pkg::RST_LINE_CTRL;
			pol_r <= tlp_pkg::RST_EDGE_POL;
			frm_r <= tlp_pkg::RST_ZERO;
			fsr_r <= tlp_pkg::RST_ZERO;
			mask_r <= tlp_pkg::RST_ZERO;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			ctrl_r <= ctrl_nxt;
			pol_r <= pol_nxt;
			frm_r <= frm_nxt;
			fsr_r <= fsr_nxt;
			mask_r <= mask_nxt;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	////////////////////////////////////////////////////////////////////////
	// receive: three-stage synchronisers, {neg, pos, clock}
	logic [2:0] s0_r, s1_r, s2_r, stab_r, stab_nxt, agree;
	logic rx_rise, rx_fall, samp_ev;
	logic rxp_r, rxp_nxt, rxn_r, rxn_nxt, rxv_r, rxv_nxt, rxs_r, rxs_nxt;
	logic fs_in_q_r, fs_in_q_nxt, viol_ev, rx_fast_sync_enable_ev, sat_ev;
	logic [CNT_W-1:0] cnt_max;

	// a change only counts once the second and third stages agree
	assign agree = ~(s1_r ^ s2_r);
	assign stab_nxt = (agree & s2_r) | (~agree & stab_r);
	assign rx_rise = stab_nxt[0] && !stab_r[0];
	assign rx_fall = !stab_nxt[0] && stab_r[0];
	assign samp_ev = rx_edge ? rx_rise : rx_fall;
	assign cnt_max = '1;
	// violations are taken on rising edges whatever the data edge is
	assign viol_ev = rx_rise && nrz && !rx_fs_en && stab_r[2];
	assign rx_fast_sync_enable_ev = samp_ev && nrz && rx_fs_en && stab_r[2] && !fs_in_q_r;
	assign sat_ev = viol_ev && (cnt_r == cnt_max) && !rd_cnt;

	// symbol capture on the selected edge
	always_comb begin
		rxp_nxt = rxp_r;
		rxn_nxt = rxn_r;
		rxv_nxt = samp_ev;
		rxs_nxt = rx_fast_sync_enable_ev;
		fs_in_q_nxt = samp_ev ? stab_r[2] : fs_in_q_r;
		if (samp_ev) begin
			if (rail) begin
				rxp_nxt = stab_r[1];
				rxn_nxt = stab_r[2];
			end else begin
				rxp_nxt = stab_r[1] ^ rx_inv;
				rxn_nxt = 1'b0;
			end
		end
	end

	// violation counter: a read clears it, an increment in that cycle survives
	always_comb begin
		cnt_nxt = rd_cnt ? '0 : cnt_r;
		if (viol_ev && (cnt_nxt != cnt_max)) begin
			cnt_nxt = cnt_nxt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s0_r <= 3'h0;
			s1_r <= 3'h0;
			s2_r <= 3'h0;
			stab_r <= 3'h0;
			rxp_r <= 1'b0;
			rxn_r <= 1'b0;
			rxv_r <= 1'b0;
			rxs_r <= 1'b0;
			fs_in_q_r <= 1'b0;
			cnt_r <= '0;
		end else begin
			s0_r <= {rx_neg_rail, rx_pos_rail, rx_line_clock};
			s1_r <= s0_r;
			s2_r <= s1_r;
			stab_r <= stab_nxt;
			rxp_r <= rxp_nxt;
			rxn_r <= rxn_nxt;
			rxv_r <= rxv_nxt;
			rxs_r <= rxs_nxt;
			fs_in_q_r <= fs_in_q_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	assign rx_pos_out = rxp_r;
	assign rx_neg_out = rxn_r;
	assign rx_valid = rxv_r;
	assign rx_frame_sync = rxs_r;

	////////////////////////////////////////////////////////////////////////
	// transmit: clock divider, bit/frame position, line outputs
	logic [7:0] div_r, div_nxt, bit_r, bit_nxt;
	logic [4:0] frame_r, frame_nxt;
	logic tck_r, tck_nxt, tick, t_rise, t_fall, launch;
	logic fs_r, fs_nxt, txp_r, txp_nxt, txn_r, txn_nxt, req_r, req_nxt, tx_fast_sync_enable_ev;

	assign tick = (div_r == tlp_pkg::TX_HALF_LAST);
	assign t_rise = tick && !tck_r;
	assign t_fall = tick && tck_r;
	assign launch = tx_edge ? t_rise : t_fall;
	assign tx_fast_sync_enable_ev = launch && fs_nxt && nrz && tx_fs_en;

	// divider and position next values
	always_comb begin
		div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
		tck_nxt = tick ? !tck_r : tck_r;
		bit_nxt = bit_r;
		frame_nxt = frame_r;
		fs_nxt = fs_r;
		if (launch) begin
			if (bit_r == tlp_pkg::FRAME_BITS) begin
				bit_nxt = 8'h01;
				frame_nxt = (frame_r == tlp_pkg::LAST_FRAME) ? 5'h00 : 5'(frame_r + 5'h01);
			end else begin
				bit_nxt = 8'(bit_r + 8'h01);
			end
			// sf marks frame 12 of every other superframe, once per 24 frames
			fs_nxt = (bit_nxt == tlp_pkg::FS_BIT) &&
				((esf && frame_nxt == tlp_pkg::ESF_FS_FRAME) ||
				(sf && frame_nxt == tlp_pkg::SF_FS_FRAME));
		end
	end

	// line outputs; symbols are sampled at the launch edge
	always_comb begin
		txp_nxt = txp_r;
		txn_nxt = txn_r;
		req_nxt = launch;
		if (rail && launch) begin
			txp_nxt = tx_pos_in;
			// a symbol with both rails set is sent as positive only
			txn_nxt = tx_neg_in && !tx_pos_in;
		end else if (nrz && launch) begin
			txp_nxt = (tx_pos_in || tx_neg_in) ^ tx_inv;
		end
		if (nrz && tx_fs_en && launch) begin
			txn_nxt = fs_nxt;
		end else if (nrz && !tx_fs_en && t_rise) begin
			txn_nxt = ctrl_r[tlp_pkg::BIT_GEN_OUT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 8'h00;
			tck_r <= 1'b0;
			bit_r <= 8'h01;
			frame_r <= 5'h00;
			fs_r <= 1'b0;
			txp_r <= 1'b0;
			txn_r <= 1'b0;
			req_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			tck_r <= tck_nxt;
			bit_r <= bit_nxt;
			frame_r <= frame_nxt;
			fs_r <= fs_nxt;
			txp_r <= txp_nxt;
			txn_r <= txn_nxt;
			req_r <= req_nxt;
		end
	end
	assign tx_line_clock = tck_r;
	assign tx_pos_rail = txp_r;
	assign tx_neg_rail = txn_r;
	assign tx_bit_req = req_r;

	////////////////////////////////////////////////////////////////////////
	// interrupt status: read clears, a same-cycle event wins
	always_comb begin
		stat_nxt = rd_stat ? 4'h0 : stat_r;
		stat_nxt[tlp_pkg::IRQ_VIOL] = stat_nxt[tlp_pkg::IRQ_VIOL] | viol_ev;
		stat_nxt[tlp_pkg::IRQ_RX_FS] = stat_nxt[tlp_pkg::IRQ_RX_FS] | rx_fast_sync_enable_ev;
		stat_nxt[tlp_pkg::IRQ_TX_FS] = stat_nxt[tlp_pkg::IRQ_TX_FS] | tx_fast_sync_enable_ev;
		stat_nxt[tlp_pkg::IRQ_CNT_SAT] = stat_nxt[tlp_pkg::IRQ_CNT_SAT] | sat_ev;
		irq_nxt = |(stat_r & mask_r[3:0]);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stat_r <= 4'h0;
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq_r <= irq_nxt;
		end
	end
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	localparam int TXH = tlp_pkg::TX_HALF_CYC;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_rails_exclusive;
		rail |-> !(tx_pos_rail && tx_neg_rail);
	endproperty
	a_rails_exclusive: assert property (p_rails_exclusive)
		else $error("both transmit rails high in rail mode");
	property p_tx_half_period;
		$rose(tx_line_clock) |-> ##TXH $fell(tx_line_clock);
	endproperty
	a_tx_half_period: assert property (p_tx_half_period)
		else $error("transmit line clock half period wrong");
	sequence s_launch_nrz;
		launch && nrz && $stable(pol_r) && $stable(ctrl_r);
	endsequence
	property p_tx_nrz_data;
		s_launch_nrz |=> tx_pos_rail == $past((tx_pos_in || tx_neg_in) ^ tx_inv);
	endproperty
	a_tx_nrz_data: assert property (p_tx_nrz_data)
		else $error("transmit nrz data does not follow symbol and polarity");
	property p_tx_pos_on_launch;
		$changed(tx_pos_rail) && $stable(ctrl_r) |-> $past(launch);
	endproperty
	a_tx_pos_on_launch: assert property (p_tx_pos_on_launch)
		else $error("transmit data changed away from launch edge");
	property p_gen_out;
		t_rise && nrz && !tx_fs_en && $stable(fsr_r) |=>
			tx_neg_rail == $past(ctrl_r[tlp_pkg::BIT_GEN_OUT]);
	endproperty
	a_gen_out: assert property (p_gen_out)
		else $error("general output not sent on rising edge");
	property p_fs_position;
		$rose(fs_r) |-> bit_r == tlp_pkg::FS_BIT &&
			((esf && frame_r == tlp_pkg::ESF_FS_FRAME) || (sf && frame_r == tlp_pkg::SF_FS_FRAME));
	endproperty
	a_fs_position: assert property (p_fs_position)
		else $error("transmit fast sync at wrong bit or frame");
	property p_viol_count;
		viol_ev && !rd_cnt && cnt_r != cnt_max |=> cnt_r == $past(cnt_r) + 1'b1;
	endproperty
	a_viol_count: assert property (p_viol_count)
		else $error("violation counter did not advance");
	property p_rx_rails;
		samp_ev && rail |=> rx_valid && rx_pos_out == $past(stab_r[1]) &&
			rx_neg_out == $past(stab_r[2]);
	endproperty
	a_rx_rails: assert property (p_rx_rails)
		else $error("receive rails not captured at sample edge");
	property p_rx_nrz;
		samp_ev && nrz |=> rx_pos_out == $past(stab_r[1] ^ rx_inv) && !rx_neg_out;
	endproperty
	a_rx_nrz: assert property (p_rx_nrz)
		else $error("receive nrz data wrong polarity");
	property p_rx_edge;
		rx_valid |-> $past(rx_edge ? rx_rise : rx_fall);
	endproperty
	a_rx_edge: assert property (p_rx_edge)
		else $error("receive sample on wrong line clock edge");
	property p_rx_fs_mode;
		rx_frame_sync |-> $past(nrz && rx_fs_en);
	endproperty
	a_rx_fs_mode: assert property (p_rx_fs_mode)
		else $error("receive fast sync outside its mode");

endmodule // tlp_line_port

// *** common/tlp_pkg.sv ***
// constants for the t1 line-side port: register map, field positions,
// reset values and line timing.
// assumes a 250 MHz core clock and 32-bit classic wishbone access.
package tlp_pkg;

	////////////////////////////////////////////////////////////////////////
	// clocking
	localparam int CLK_HZ = 250000000;
	localparam int LINE_HZ = 1544000;
	// half period of the generated line clock, nearest whole cycle
	localparam int TX_HALF_CYC = (CLK_HZ + LINE_HZ) / (2 * LINE_HZ);
	localparam logic [7:0] TX_HALF_LAST = 8'(TX_HALF_CYC - 1);

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_LINE_CTRL = 6'h00;
	localparam logic [5:0] IDX_EDGE_POL = 6'h01;
	localparam logic [5:0] IDX_FRAMING = 6'h04;
	localparam logic [5:0] IDX_FAST_SYNC = 6'h06;
	localparam logic [5:0] IDX_VIOL_CNT = 6'h10;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h11;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h12;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int BIT_RAIL = 7;
	localparam int BIT_GEN_OUT = 6;
	localparam int BIT_RX_INV = 0;
	localparam int BIT_TX_INV = 5;
	localparam int BIT_RX_EDGE = 6;
	localparam int BIT_TX_EDGE = 7;
	localparam int BIT_FMD_LO = 1;
	localparam int BIT_FMD_HI = 2;
	localparam int BIT_TX_FS = 0;
	localparam int BIT_RX_FS = 1;
	localparam int IRQ_VIOL = 0;
	localparam int IRQ_RX_FS = 1;
	localparam int IRQ_TX_FS = 2;
	localparam int IRQ_CNT_SAT = 3;

	////////////////////////////////////////////////////////////////////////
	// writable bits and reset values
	localparam logic [7:0] WM_LINE_CTRL = 8'hc0;
	localparam logic [7:0] WM_EDGE_POL = 8'he1;
	localparam logic [7:0] WM_FRAMING = 8'h06;
	localparam logic [7:0] WM_FAST_SYNC = 8'h03;
	localparam logic [7:0] WM_IRQ = 8'h0f;
	localparam logic [7:0] RST_LINE_CTRL = 8'h80;
	localparam logic [7:0] RST_EDGE_POL = 8'hc0;
	localparam logic [7:0] RST_ZERO = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// framing
	localparam logic [1:0] FMD_ESF = 2'h3;
	localparam logic [1:0] FMD_SF = 2'h1;
	localparam logic [7:0] FRAME_BITS = 8'hc1;
	localparam logic [7:0] FS_BIT = 8'hc0;
	localparam logic [4:0] LAST_FRAME = 5'h17;
	localparam logic [4:0] ESF_FS_FRAME = 5'h17;
	localparam logic [4:0] SF_FS_FRAME = 5'h0b;

endpackage

// *** testbench/tlp_xcvr_model.sv ***
// line transceiver model: recovered receive clock and receive rails.
// assumes the bench gives the sampling edge, rail mode and violation gate.
`timescale 1ns/1ps
module tlp_xcvr_model (
	input wire logic rail,
	input wire logic samp_edge,
	input wire logic viol_en,
	output logic rx_line_clock,
	output logic rx_pos_rail,
	output logic rx_neg_rail
);
	int seed = 78;
	logic [1:0] r;

	////////////////////////////////////////////////////////////////////////
	// free-running recovered clock, 125 ns, no phase tie to clk
	initial begin
		rx_line_clock = 1'b0;
		rx_pos_rail = 1'b0;
		rx_neg_rail = 1'b0;
		forever #62.5 rx_line_clock = ~rx_line_clock;
	end

	// data moves on the unsampled edge so it is settled when taken
	always @(rx_line_clock) begin
		if (rx_line_clock !== samp_edge) begin
			r = 2'($random(seed));
			if (rail) begin
				rx_pos_rail <= r[0];
				rx_neg_rail <= r[1] & ~r[0]; // a pulse has one polarity
			end else begin
				rx_pos_rail <= r[0];
				rx_neg_rail <= r[1] & viol_en;
			end
		end
	end
endmodule // tlp_xcvr_model

// *** testbench/tb_tlp_line_port.sv ***
// bench for the line-side port: register bus, rx and tx line traffic,
// violation counting, receive fast sync and interrupt.
// assumes the transceiver model drives the receive side.
`timescale 1ns/1ps
module tb_tlp_line_port;
	logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
	logic [7:0] wb_adr_i, cfg_lc, cfg_ep;
	logic [31:0] wb_dat_i, wb_dat_o, v;
	logic rx_line_clock, rx_pos_rail, rx_neg_rail, tx_line_clock, tx_pos_rail, tx_neg_rail;
	logic rx_pos_out, rx_neg_out, rx_valid, rx_frame_sync, tx_pos_in, tx_neg_in, tx_bit_req;
	logic viol_en, rx_chk, tx_chk, tlc_prev, rise_seen;
	logic [1:0] s;
	logic [1:0] rx_q[$];
	logic [1:0] tx_q[$];
	int n_errors, n_tests, exp_viol, fs_seen, rx_pops, tx_pops, per_cnt;
	int seed = 78;
	logic [7:0] lc_t[4] = '{8'h80, 8'h80, 8'h00, 8'h40};
	logic [7:0] ep_t[4] = '{8'hc0, 8'h00, 8'hc0, 8'h21};

	tlp_line_port tlp_line_port_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
		.rx_line_clock(rx_line_clock), .rx_pos_rail(rx_pos_rail), .rx_neg_rail(rx_neg_rail),
		.tx_line_clock(tx_line_clock), .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail),
		.rx_pos_out(rx_pos_out), .rx_neg_out(rx_neg_out), .rx_valid(rx_valid),
		.rx_frame_sync(rx_frame_sync), .tx_pos_in(tx_pos_in), .tx_neg_in(tx_neg_in),
		.tx_bit_req(tx_bit_req));
	tlp_xcvr_model tlp_xcvr_model_i (.rail(cfg_lc[7]), .samp_edge(cfg_ep[6]), .viol_en(viol_en),
		.rx_line_clock(rx_line_clock), .rx_pos_rail(rx_pos_rail), .rx_neg_rail(rx_neg_rail));

	////////////////////////////////////////////////////////////////////////
	// reporting
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// wishbone master; waits on ack, no assumed latency
	task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d,
		output logic [31:0] r);
		int i;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= {24'h0, d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (i >= 50) begin
			n_errors++;
			$display("Error at %0t: no bus answer", $time);
			stop_test();
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, v);
	endtask

	////////////////////////////////////////////////////////////////////////
	// clock, watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		$display("Error at %0t: run too long", $time);
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////
	// expected rx symbols noted at the sampling edge; violations counted
	always @(rx_line_clock) begin
		if (rx_chk && rx_line_clock === cfg_ep[6])
			rx_q.push_back(cfg_lc[7] ? {rx_neg_rail, rx_pos_rail} : {1'b0, rx_pos_rail ^ cfg_ep[0]});
	end

	always @(posedge rx_line_clock) begin
		if (rx_neg_rail === 1'b1)
			exp_viol++;
	end

	// watcher: rx symbols, tx launches and period; tx symbols fed on request
	always @(posedge clk) begin
		if (rx_valid === 1'b1 && rx_chk && rx_q.size() > 0) begin
			check(32'({rx_neg_out, rx_pos_out}), 32'(rx_q.pop_front()));
			rx_pops++;
		end
		if (rx_frame_sync === 1'b1)
			fs_seen++;
		per_cnt++;
		if (tx_line_clock !== tlc_prev) begin
			if (tx_line_clock === 1'b1 && rise_seen)
				check(32'(per_cnt), 32'(2 * tlp_pkg::TX_HALF_CYC));
			if (tx_line_clock === 1'b1) begin
				per_cnt = 0;
				rise_seen = 1'b1;
			end
			if (tx_line_clock === cfg_ep[7] && tx_chk && tx_q.size() > 0) begin
				check(32'({tx_neg_rail, tx_pos_rail}), 32'(tx_q.pop_front()));
				tx_pops++;
			end
		end
		tlc_prev = tx_line_clock;
		if (tx_bit_req === 1'b1) begin
			s = 2'($random(seed));
			tx_pos_in <= s[0];
			tx_neg_in <= s[1];
			// both rails asked at once goes out as positive only
			if (tx_chk)
				tx_q.push_back(cfg_lc[7] ? {s[1] & ~s[0], s[0]} : {cfg_lc[6], (s[0] | s[1]) ^ cfg_ep[5]});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one line configuration, checked in both directions
	task automatic sync_rx();
		@(rx_line_clock iff rx_line_clock === cfg_ep[6]);
		repeat (10) @(posedge clk);
	endtask

	task automatic phase(input logic [7:0] lc, input logic [7:0] ep);
		wr(tlp_pkg::IDX_LINE_CTRL, lc);
		wr(tlp_pkg::IDX_EDGE_POL, ep);
		cfg_lc = lc;
		cfg_ep = ep;
		rx_pops = 0;
		tx_pops = 0;
		repeat (8) @(posedge rx_line_clock);
		sync_rx();
		rx_chk <= 1'b1;
		tx_chk <= 1'b1;
		repeat (120) @(posedge rx_line_clock);
		sync_rx();
		rx_chk <= 1'b0;
		tx_chk <= 1'b0;
		@(posedge clk);
		check(32'(rx_q.size()), 32'h0);
		check(32'(rx_pops > 100), 32'h1);
		check(32'(tx_pops > 15), 32'h1);
		rx_q.delete();
		tx_q.delete();
	endtask

	// violation burst; counter, status and irq read back afterwards
	task automatic viol_run(input logic fs, input logic [31:0] ei, input logic [31:0] es);
		repeat (4) @(posedge rx_line_clock);
		bus(1'b0, tlp_pkg::IDX_VIOL_CNT, 8'h00, v);
		bus(1'b0, tlp_pkg::IDX_IRQ_STAT, 8'h00, v);
		exp_viol = 0;
		@(posedge clk);
		viol_en <= 1'b1;
		repeat (40) @(posedge rx_line_clock);
		@(posedge clk);
		viol_en <= 1'b0;
		repeat (4) @(posedge rx_line_clock);
		check(32'(irq), ei);
		bus(1'b0, tlp_pkg::IDX_VIOL_CNT, 8'h00, v);
		check(v, fs ? 32'h0 : 32'(exp_viol));
		bus(1'b0, tlp_pkg::IDX_IRQ_STAT, 8'h00, v);
		check(v, es);
		repeat (3) @(posedge clk);
		check(32'(irq), 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		tx_pos_in = 1'b0;
		tx_neg_in = 1'b0;
		cfg_lc = 8'h80;
		cfg_ep = 8'hc0;
		viol_en = 1'b0;
		rx_chk = 1'b0;
		tx_chk = 1'b0;
		tlc_prev = 1'b0;
		rise_seen = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, tlp_pkg::IDX_LINE_CTRL, 8'h00, v);
		check(v, 32'h80);
		bus(1'b0, tlp_pkg::IDX_EDGE_POL, 8'h00, v);
		check(v, 32'hc0);
		bus(1'b0, 6'h3f, 8'h00, v);
		check(v, 32'h0);
		wr(tlp_pkg::IDX_LINE_CTRL, 8'h3f);
		bus(1'b0, tlp_pkg::IDX_LINE_CTRL, 8'h00, v);
		check(v, 32'h0);
		wr(tlp_pkg::IDX_FRAMING, 8'h06);
		bus(1'b0, tlp_pkg::IDX_FRAMING, 8'h00, v);
		check(v, 32'h06);
		for (int k = 0; k < 4; k++)
			phase(lc_t[k], ep_t[k]);
		// nrz with counting, then masked, then receive fast sync
		wr(tlp_pkg::IDX_LINE_CTRL, 8'h00);
		wr(tlp_pkg::IDX_EDGE_POL, 8'hc0);
		cfg_lc = 8'h00;
		cfg_ep = 8'hc0;
		wr(tlp_pkg::IDX_IRQ_MASK, 8'h01);
		viol_run(1'b0, 32'h1, 32'h01);
		wr(tlp_pkg::IDX_IRQ_MASK, 8'h00);
		viol_run(1'b0, 32'h0, 32'h01);
		wr(tlp_pkg::IDX_FAST_SYNC, 8'h02);
		wr(tlp_pkg::IDX_IRQ_MASK, 8'h02);
		fs_seen = 0;
		viol_run(1'b1, 32'h1, 32'h02);
		check(32'(fs_seen > 0), 32'h1);
		stop_test();
	end
endmodule // tb_tlp_line_port
